// *** gtm_defs.svh ***
// constants for the gated timer block: register offsets, fields, reset values
// assumes an apb master with 32-bit data; offsets are byte addresses
`ifndef GTM_DEFS_SVH
`define GTM_DEFS_SVH
`define GTM_OFF_CTRL   12'h000
`define GTM_OFF_GATE   12'h004
`define GTM_OFF_COUNT  12'h008
`define GTM_OFF_FLAGS  12'h00C
`define GTM_OFF_CAP    12'h010
`define GTM_OFF_ENA    12'h014
`define GTM_CTRL_ON    0
`define GTM_CTRL_SYNC  1
`define GTM_GATE_GE    0
`define GTM_GATE_POL   1
`define GTM_GATE_TM    2
`define GTM_GATE_SPM   3
`define GTM_GATE_GO    4
`define GTM_GATE_VAL   5
`define GTM_GATE_SRC   6
`define GTM_GATE_SRCW  2
`define GTM_FLG_ROLL   0
`define GTM_FLG_GATE   1
`define GTM_ENA_ROLL   0
`define GTM_ENA_GATE   1
`define GTM_ENA_PER    2
`define GTM_ENA_GLB    3
`define GTM_CNT_MAX    16'hFFFF
`define GTM_CNT_ZERO   16'h0000
`endif

// *** gtm_pkg.sv ***
// types for the gated timer block
// assumes gtm_defs.svh for numeric constants
package gtm_pkg;
	typedef enum logic [1:0] {
		GTM_SRC_PIN   = 2'b00,
		GTM_SRC_TOVF  = 2'b01,
		GTM_SRC_CMP1  = 2'b10,
		GTM_SRC_CMP2  = 2'b11
	} gtm_src_type;
	typedef enum logic [1:0] {
		GTM_SP_IDLE   = 2'b00,
		GTM_SP_ARMED  = 2'b01,
		GTM_SP_ACTIVE = 2'b10
	} gtm_sp_type;
endpackage

// *** gtm_timer.sv ***
// gated 16-bit up-counter: gate sources, toggle, single pulse, events, capture/compare
// assumes inputs synchronous to CLOCK and an apb master
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "gtm_defs.svh"
module gtm_timer
	import gtm_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        COUNT_TICK,
	input  wire logic        GATE_PIN,
	input  wire logic        COMPANION_OVF,
	input  wire logic        COMPANION_8BIT,
	input  wire logic        COMPANION_PMATCH,
	input  wire logic        CMP1_OUT,
	input  wire logic        CMP1_SYNC,
	input  wire logic        CMP2_OUT,
	input  wire logic        CMP2_SYNC,
	input  wire logic        CAPTURE_EVENT,
	input  wire logic        COMPARE_MODE,
	input  wire logic        AUTO_TRIG_EN,
	input  wire logic        TRIG_OTHER,
	input  wire logic        SLEEPING,
	output logic             COMPARE_EVENT,
	output logic             AUTO_TRIGGER,
	output logic             IRQ,
	output logic             WAKE
);
	logic [15:0] count_q;
	logic [15:0] capcomp_q;
	logic        on_q, sync_q;
	logic        ge_q, pol_q, tm_q, spm_q, go_q;
	gtm_src_type src_q;
	logic        roll_en_q, gate_en_q, per_en_q, glb_en_q;
	logic        roll_flag_q, gate_flag_q;
	logic        cmp1_q, cmp2_q, pulse_q;
	logic        tog_q, gate_level_status_q, gprev_q;
	logic [31:0] rdata_d;

	wire wr  = PSEL && PENABLE && PWRITE;
	wire rd  = PSEL && !PENABLE && !PWRITE;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	// gate source selection
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pulse_q <= 1'b0;
			cmp1_q  <= 1'b0;
			cmp2_q  <= 1'b0;
		end else begin
			pulse_q <= COMPANION_8BIT ? COMPANION_PMATCH : COMPANION_OVF;
			cmp1_q  <= CMP1_OUT;
			cmp2_q  <= CMP2_OUT;
		end
	end
	logic src_raw;
	always_comb begin
		unique case (src_q)
			GTM_SRC_PIN:  src_raw = GATE_PIN;
			GTM_SRC_TOVF: src_raw = pulse_q;
			GTM_SRC_CMP1: src_raw = CMP1_SYNC ? cmp1_q : CMP1_OUT;
			GTM_SRC_CMP2: src_raw = CMP2_SYNC ? cmp2_q : CMP2_OUT;
		endcase
	end
	wire src_pol = pol_q ? src_raw : !src_raw;
	logic src_prev_q;
	wire src_rise = src_pol && !src_prev_q;

	// toggle flip-flop
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			src_prev_q <= 1'b0;
			tog_q      <= 1'b0;
		end else begin
			src_prev_q <= src_pol;
			if (!tm_q)
				tog_q <= 1'b0;
			else if (src_rise)
				tog_q <= !tog_q;
		end
	end
	wire gate_lvl = tm_q ? tog_q : src_pol;
	// single pulse: go opens at the first gate rise, trailing edge closes it
	logic sp_open_q;
	wire gate_ctl = spm_q ? (gate_lvl && go_q && (sp_open_q || !gprev_q)) : gate_lvl;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			gate_level_status_q  <= 1'b0;
			gprev_q <= 1'b0;
		end else begin
			gate_level_status_q  <= gate_ctl;
			gprev_q <= gate_lvl;
		end
	end
	wire gate_fall = gprev_q && !gate_lvl;
	wire gate_level_status_fall = gate_level_status_q && !gate_ctl;

	wire tick  = COUNT_TICK && on_q && (!ge_q || gate_ctl);
	wire match = COMPARE_MODE && (capcomp_q == count_q);
	wire trig  = (match && AUTO_TRIG_EN && !sync_q) || TRIG_OTHER;
	wire wr_count = wr && hit(PADDR, `GTM_OFF_COUNT);

	// counter
	always_ff @(posedge CLOCK) begin
		if (RST)
			count_q <= `GTM_CNT_ZERO;
		else if (wr_count)
			count_q <= PWDATA[15:0];
		else if (trig)
			count_q <= `GTM_CNT_ZERO;
		else if (tick)
			count_q <= count_q + 16'h0001;
	end
	wire roll_set = tick && !wr_count && !trig && (count_q == `GTM_CNT_MAX);

	// capture/compare register
	always_ff @(posedge CLOCK) begin
		if (RST)
			capcomp_q <= `GTM_CNT_ZERO;
		else if (CAPTURE_EVENT && !COMPARE_MODE)
			capcomp_q <= count_q;
		else if (wr && hit(PADDR, `GTM_OFF_CAP))
			capcomp_q <= PWDATA[15:0];
	end

	// control registers
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			on_q <= 1'b0; sync_q <= 1'b0;
			ge_q <= 1'b0; pol_q <= 1'b0; tm_q <= 1'b0; spm_q <= 1'b0;
			src_q <= GTM_SRC_PIN;
			roll_en_q <= 1'b0; gate_en_q <= 1'b0; per_en_q <= 1'b0; glb_en_q <= 1'b0;
		end else if (wr) begin
			if (hit(PADDR, `GTM_OFF_CTRL)) begin
				on_q   <= PWDATA[`GTM_CTRL_ON];
				sync_q <= PWDATA[`GTM_CTRL_SYNC];
			end
			if (hit(PADDR, `GTM_OFF_GATE)) begin
				ge_q  <= PWDATA[`GTM_GATE_GE];
				pol_q <= PWDATA[`GTM_GATE_POL];
				tm_q  <= PWDATA[`GTM_GATE_TM];
				spm_q <= PWDATA[`GTM_GATE_SPM];
				src_q <= gtm_src_type'(PWDATA[`GTM_GATE_SRC +: `GTM_GATE_SRCW]);
			end
			if (hit(PADDR, `GTM_OFF_ENA)) begin
				roll_en_q <= PWDATA[`GTM_ENA_ROLL];
				gate_en_q <= PWDATA[`GTM_ENA_GATE];
				per_en_q  <= PWDATA[`GTM_ENA_PER];
				glb_en_q  <= PWDATA[`GTM_ENA_GLB];
			end
		end
	end

	// go/done and single pulse window
	wire wr_gate = wr && hit(PADDR, `GTM_OFF_GATE);
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			go_q      <= 1'b0;
			sp_open_q <= 1'b0;
		end else if (spm_q && go_q && sp_open_q && gate_fall) begin
			go_q      <= 1'b0;
			sp_open_q <= 1'b0;
		end else begin
			if (wr_gate)
				go_q <= PWDATA[`GTM_GATE_GO];
			if (spm_q && go_q && gate_lvl && !gprev_q)
				sp_open_q <= 1'b1;
			else if (!go_q)
				sp_open_q <= 1'b0;
		end
	end

	// flags: hardware set wins over software clear (write one to clear)
	wire wr_flags = wr && hit(PADDR, `GTM_OFF_FLAGS);
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			roll_flag_q <= 1'b0;
			gate_flag_q <= 1'b0;
		end else begin
			if (roll_set)
				roll_flag_q <= 1'b1;
			else if (wr_flags && PWDATA[`GTM_FLG_ROLL])
				roll_flag_q <= 1'b0;
			if (gate_level_status_fall)
				gate_flag_q <= 1'b1;
			else if (wr_flags && PWDATA[`GTM_FLG_GATE])
				gate_flag_q <= 1'b0;
		end
	end

	// outputs
	wire roll_req = roll_flag_q && roll_en_q && per_en_q;
	wire gate_req = gate_flag_q && gate_en_q && per_en_q;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			IRQ           <= 1'b0;
			WAKE          <= 1'b0;
			COMPARE_EVENT <= 1'b0;
			AUTO_TRIGGER  <= 1'b0;
		end else begin
			IRQ           <= (roll_req || gate_req) && glb_en_q && !SLEEPING;
			WAKE          <= SLEEPING && roll_req && on_q && sync_q;
			COMPARE_EVENT <= match;
			AUTO_TRIGGER  <= match && AUTO_TRIG_EN;
		end
	end

	// apb read path, zero wait states
	always_comb begin
		rdata_d = 32'h00000000;
		unique case (PADDR)
			`GTM_OFF_CTRL: begin
				rdata_d[`GTM_CTRL_ON]   = on_q;
				rdata_d[`GTM_CTRL_SYNC] = sync_q;
			end
			`GTM_OFF_GATE: begin
				rdata_d[`GTM_GATE_GE]  = ge_q;
				rdata_d[`GTM_GATE_POL] = pol_q;
				rdata_d[`GTM_GATE_TM]  = tm_q;
				rdata_d[`GTM_GATE_SPM] = spm_q;
				rdata_d[`GTM_GATE_GO]  = go_q;
				rdata_d[`GTM_GATE_VAL] = gate_level_status_q;
				rdata_d[`GTM_GATE_SRC +: `GTM_GATE_SRCW] = src_q;
			end
			`GTM_OFF_COUNT: rdata_d[15:0] = count_q;
			`GTM_OFF_FLAGS: begin
				rdata_d[`GTM_FLG_ROLL] = roll_flag_q;
				rdata_d[`GTM_FLG_GATE] = gate_flag_q;
			end
			`GTM_OFF_CAP: rdata_d[15:0] = capcomp_q;
			`GTM_OFF_ENA: begin
				rdata_d[`GTM_ENA_ROLL] = roll_en_q;
				rdata_d[`GTM_ENA_GATE] = gate_en_q;
				rdata_d[`GTM_ENA_PER]  = per_en_q;
				rdata_d[`GTM_ENA_GLB]  = glb_en_q;
			end
			default: rdata_d = 32'h00000000;
		endcase
	end
	wire mapped = (PADDR <= `GTM_OFF_ENA) && (PADDR[1:0] == 2'b00);
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PRDATA  <= 32'h00000000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			if (rd)
				PRDATA <= rdata_d;
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped;
		end
	end

	// checks
	rollover_wrap_a: assert property (@(posedge CLOCK) disable iff (RST)
		roll_set |=> (count_q == `GTM_CNT_ZERO) && roll_flag_q)
		else $error("rollover did not wrap and flag");
	flag_sticky_a: assert property (@(posedge CLOCK) disable iff (RST)
		roll_flag_q && !(wr_flags && PWDATA[`GTM_FLG_ROLL]) |=> roll_flag_q)
		else $error("rollover flag dropped without clear");
	toggle_held_a: assert property (@(posedge CLOCK) disable iff (RST)
		!tm_q |=> !tog_q)
		else $error("toggle flop not held clear");
	toggle_flip_a: assert property (@(posedge CLOCK) disable iff (RST)
		tm_q && src_rise |=> tog_q != $past(tog_q))
		else $error("toggle flop missed an edge");
	gate_event_a: assert property (@(posedge CLOCK) disable iff (RST)
		gate_level_status_fall |=> gate_flag_q)
		else $error("gate event flag not set");
	trig_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		trig && !wr_count |=> count_q == `GTM_CNT_ZERO && !roll_set)
		else $error("trigger did not clear counter");
	write_wins_a: assert property (@(posedge CLOCK) disable iff (RST)
		wr_count |=> count_q == $past(PWDATA[15:0]))
		else $error("counter write lost");
	pulse_done_a: assert property (@(posedge CLOCK) disable iff (RST)
		spm_q && go_q && sp_open_q && gate_fall |=> !go_q)
		else $error("go not cleared at trailing edge");
	capture_copy_a: assert property (@(posedge CLOCK) disable iff (RST)
		CAPTURE_EVENT && !COMPARE_MODE |=> capcomp_q == $past(count_q))
		else $error("capture did not copy counter");
	gate_status_a: assert property (@(posedge CLOCK) disable iff (RST)
		1'b1 |=> gate_level_status_q == $past(gate_ctl))
		else $error("gate status stale");
	pulse_src_a: assert property (@(posedge CLOCK) disable iff (RST)
		1'b1 |=> pulse_q == ($past(COMPANION_8BIT) ? $past(COMPANION_PMATCH) : $past(COMPANION_OVF)))
		else $error("companion pulse not passed");
	cmp_sync_a: assert property (@(posedge CLOCK) disable iff (RST)
		src_q == GTM_SRC_CMP1 && CMP1_SYNC |-> src_raw == cmp1_q)
		else $error("synced comparator not selected");
	cmp_raw_a: assert property (@(posedge CLOCK) disable iff (RST)
		src_q == GTM_SRC_CMP2 && !CMP2_SYNC |-> src_raw == CMP2_OUT)
		else $error("raw comparator not selected");
	toggle_keep_a: assert property (@(posedge CLOCK) disable iff (RST)
		tm_q && !src_rise |=> tog_q == $past(tog_q))
		else $error("toggle flop flipped without edge");
	single_arm_a: assert property (@(posedge CLOCK) disable iff (RST)
		spm_q && !go_q |-> !gate_ctl)
		else $error("gate open without go");
	pulse_ignore_a: assert property (@(posedge CLOCK) disable iff (RST)
		spm_q && !go_q |=> !sp_open_q)
		else $error("pulse window opened without go");
	go_write_a: assert property (@(posedge CLOCK) disable iff (RST)
		wr_gate && !(spm_q && go_q && sp_open_q && gate_fall) |=> go_q == $past(PWDATA[`GTM_GATE_GO]))
		else $error("go write lost");
	combo_stop_a: assert property (@(posedge CLOCK) disable iff (RST)
		spm_q && tm_q && !go_q |-> !gate_ctl)
		else $error("toggle pulse kept counting");
	gate_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
		on_q && ge_q && !gate_ctl && !wr_count && !trig |=> count_q == $past(count_q))
		else $error("count moved with gate closed");
	free_run_a: assert property (@(posedge CLOCK) disable iff (RST)
		COUNT_TICK && on_q && !ge_q && !wr_count && !trig |=> count_q == $past(count_q) + 16'h0001)
		else $error("free running count missed tick");
	off_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
		!on_q && !wr_count && !trig |=> count_q == $past(count_q))
		else $error("count moved while off");
	gate_sticky_a: assert property (@(posedge CLOCK) disable iff (RST)
		gate_flag_q && !(wr_flags && PWDATA[`GTM_FLG_GATE]) |=> gate_flag_q)
		else $error("gate flag dropped without clear");
	irq_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
		gate_req && glb_en_q && !SLEEPING |=> IRQ)
		else $error("gate irq not raised");
	irq_sleep_a: assert property (@(posedge CLOCK) disable iff (RST)
		SLEEPING |=> !IRQ)
		else $error("irq raised in sleep");
	wake_raise_a: assert property (@(posedge CLOCK) disable iff (RST)
		SLEEPING && roll_req && on_q && sync_q |=> WAKE)
		else $error("no wake on rollover");
	wake_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
		!SLEEPING |=> !WAKE)
		else $error("wake while awake");
	compare_evt_a: assert property (@(posedge CLOCK) disable iff (RST)
		match |=> COMPARE_EVENT)
		else $error("compare event missing");
	auto_trig_a: assert property (@(posedge CLOCK) disable iff (RST)
		match && AUTO_TRIG_EN |=> AUTO_TRIGGER)
		else $error("auto trigger missing");
	other_trig_a: assert property (@(posedge CLOCK) disable iff (RST)
		TRIG_OTHER && !wr_count |=> count_q == `GTM_CNT_ZERO)
		else $error("other unit trigger did not clear");
	trig_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
		trig |-> !roll_set)
		else $error("trigger set rollover");
endmodule // gtm_timer

// *** gtm_partner.sv ***
// gate source model: gate pin, companion timer pulses, comparator levels
// assumes requests from the bench, changed just after rising edges
`timescale 1ns/10ps
module gtm_partner (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       pin_lvl,
	input  wire logic [1:0] pulse_req,
	input  wire logic [1:0] cmp_lvl,
	output logic            gate_pin,
	output logic            ovf,
	output logic            pmatch,
	output logic [1:0]      cmp_out
);
	always_ff @(posedge clock) begin
		if (rst) begin
			gate_pin <= 1'h0;
			ovf      <= 1'h0;
			pmatch   <= 1'h0;
			cmp_out  <= 2'h0;
		end else begin
			gate_pin <= pin_lvl;
			ovf      <= pulse_req[0];
			pmatch   <= pulse_req[1];
			cmp_out  <= cmp_lvl;
		end
	end
endmodule // gtm_partner

// *** gtm_timer_bench.sv ***
// self-checking bench: apb master, gate sources, counter model
// assumes gtm_timer, gtm_partner and the constants header
`timescale 1ns/10ps
`include "gtm_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end
module gtm_timer_bench
	import gtm_pkg::*;
;
	logic        CLOCK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
	logic        PREADY, PSLVERR, rerr, COMPARE_EVENT, AUTO_TRIGGER, IRQ, WAKE;
	logic        COUNT_TICK = 1'h0, COMPANION_8BIT = 1'h0, CMP1_SYNC = 1'h0, CMP2_SYNC = 1'h0;
	logic        CAPTURE_EVENT = 1'h0, COMPARE_MODE = 1'h0, AUTO_TRIG_EN = 1'h0;
	logic        TRIG_OTHER = 1'h0, SLEEPING = 1'h0, pin_lvl = 1'h0, seen_cmp = 1'h0;
	logic        GATE_PIN, COMPANION_OVF, COMPANION_PMATCH;
	logic [1:0]  pulse_req = 2'h0, cmp_lvl = 2'h0, cmp_out;
	int          errors = 0, n_checks = 0, cyc = 0, mcnt = 0, seed = 32'h3C72;

	gtm_partner src_u (.clock(CLOCK), .rst(RST), .pin_lvl(pin_lvl), .pulse_req(pulse_req),
		.cmp_lvl(cmp_lvl), .gate_pin(GATE_PIN), .ovf(COMPANION_OVF),
		.pmatch(COMPANION_PMATCH), .cmp_out(cmp_out));
	gtm_timer dut_u (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .COUNT_TICK(COUNT_TICK), .GATE_PIN(GATE_PIN),
		.COMPANION_OVF(COMPANION_OVF), .COMPANION_8BIT(COMPANION_8BIT),
		.COMPANION_PMATCH(COMPANION_PMATCH), .CMP1_OUT(cmp_out[0]), .CMP1_SYNC(CMP1_SYNC),
		.CMP2_OUT(cmp_out[1]), .CMP2_SYNC(CMP2_SYNC), .CAPTURE_EVENT(CAPTURE_EVENT),
		.COMPARE_MODE(COMPARE_MODE), .AUTO_TRIG_EN(AUTO_TRIG_EN), .TRIG_OTHER(TRIG_OTHER),
		.SLEEPING(SLEEPING), .COMPARE_EVENT(COMPARE_EVENT), .AUTO_TRIGGER(AUTO_TRIGGER),
		.IRQ(IRQ), .WAKE(WAKE));

	initial begin
		forever #2.5 CLOCK = ~CLOCK;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	always @(posedge CLOCK) begin
		cyc++;
		if (COMPARE_EVENT === 1'h1 && AUTO_TRIGGER === 1'h1) seen_cmp <= 1'h1;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'h1;
		do @(posedge CLOCK); while (PREADY !== 1'h1);
		rdat = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask

	task automatic tick(input int n, input logic c);
		repeat (n) begin
			@(posedge CLOCK);
			COUNT_TICK <= 1'h1;
			@(posedge CLOCK);
			COUNT_TICK <= 1'h0;
		end
		repeat (3) @(posedge CLOCK);
		if (c) mcnt = (mcnt + n) & 'hFFFF;
	endtask

	task automatic pin(input logic l);
		pin_lvl <= l;
		repeat (4) @(posedge CLOCK);
	endtask

	task automatic pulse(input logic [1:0] r);
		pulse_req <= r;
		@(posedge CLOCK);
		pulse_req <= 2'h0;
		repeat (4) @(posedge CLOCK);
	endtask

	task automatic gw(input gtm_src_type s, input logic [4:0] b);
		apb(1'h1, `GTM_OFF_GATE, {24'h0, s, 1'h0, b});
	endtask

	task automatic rd(input logic [11:0] a);
		apb(1'h0, a, 32'h0);
	endtask

	initial begin
		repeat (12) @(posedge CLOCK);
		RST <= 1'h0;
		apb(1'h1, `GTM_OFF_CTRL, 32'h1);
		apb(1'h1, `GTM_OFF_ENA, 32'hF);
		rd(12'h018);
		`CHK({rerr, rdat}, 33'h100000000)
		apb(1'h1, `GTM_OFF_FLAGS, 32'h3);
		mcnt = 'hFFFE;
		apb(1'h1, `GTM_OFF_COUNT, mcnt);
		tick(3, 1'h1);
		rd(`GTM_OFF_COUNT);
		`CHK(rdat[15:0], mcnt[15:0])
		rd(`GTM_OFF_FLAGS);
		`CHK(rdat[`GTM_FLG_ROLL], 1'h1)
		`CHK(IRQ, 1'h1)
		SLEEPING <= 1'h1;
		apb(1'h1, `GTM_OFF_CTRL, 32'h3);
		repeat (2) @(posedge CLOCK);
		`CHK({WAKE, IRQ}, 2'h2)
		SLEEPING <= 1'h0;
		apb(1'h1, `GTM_OFF_CTRL, 32'h1);
		rd(`GTM_OFF_FLAGS);
		`CHK(rdat[`GTM_FLG_ROLL], 1'h1)
		apb(1'h1, `GTM_OFF_FLAGS, 32'h3);
		for (int p = 0; p < 2; p++) begin
			gw(GTM_SRC_PIN, {3'h0, p[0], 1'h1});
			for (int l = 0; l < 2; l++) begin
				pin(l[0]);
				tick(5, l == p);
				rd(`GTM_OFF_COUNT);
				`CHK(rdat[15:0], mcnt[15:0])
			end
		end
		gw(GTM_SRC_PIN, 5'h02);
		pin(1'h1);
		rd(`GTM_OFF_GATE);
		`CHK(rdat[`GTM_GATE_VAL], 1'h1)
		apb(1'h1, `GTM_OFF_FLAGS, 32'h3);
		pin(1'h0);
		rd(`GTM_OFF_FLAGS);
		`CHK(rdat[`GTM_FLG_GATE], 1'h1)
		`CHK(IRQ, 1'h1)
		apb(1'h1, `GTM_OFF_FLAGS, 32'h3);
		gw(GTM_SRC_TOVF, 5'h06);
		for (int i = 0; i < 5; i++) begin
			COMPANION_8BIT <= i[1];
			pulse(i[1] ? 2'h2 : 2'h1);
			rd(`GTM_OFF_GATE);
			`CHK(rdat[`GTM_GATE_VAL], ~i[0])
		end
		gw(GTM_SRC_TOVF, 5'h02);
		gw(GTM_SRC_TOVF, 5'h06);
		rd(`GTM_OFF_GATE);
		`CHK(rdat[`GTM_GATE_VAL], 1'h0)
		for (int j = 0; j < 4; j++) begin
			CMP1_SYNC <= j[0];
			CMP2_SYNC <= j[0];
			gw(j[1] ? GTM_SRC_CMP2 : GTM_SRC_CMP1, 5'h02);
			for (int l = 0; l < 2; l++) begin
				cmp_lvl <= j[1] ? {l[0], ~l[0]} : {~l[0], l[0]};
				repeat (4) @(posedge CLOCK);
				rd(`GTM_OFF_GATE);
				`CHK(rdat[`GTM_GATE_VAL], l[0])
			end
		end
		cmp_lvl <= 2'h0;
		pin(1'h0);
		gw(GTM_SRC_PIN, 5'h0B);
		gw(GTM_SRC_PIN, 5'h1B);
		pin(1'h1);
		tick(4, 1'h1);
		pin(1'h0);
		rd(`GTM_OFF_GATE);
		`CHK(rdat[`GTM_GATE_GO], 1'h0)
		pin(1'h1);
		tick(4, 1'h0);
		rd(`GTM_OFF_COUNT);
		`CHK(rdat[15:0], mcnt[15:0])
		gw(GTM_SRC_PIN, 5'h00);
		mcnt = $random(seed) & 'hFFFF;
		apb(1'h1, `GTM_OFF_COUNT, mcnt);
		CAPTURE_EVENT <= 1'h1;
		@(posedge CLOCK);
		CAPTURE_EVENT <= 1'h0;
		rd(`GTM_OFF_CAP);
		`CHK(rdat[15:0], mcnt[15:0])
		apb(1'h1, `GTM_OFF_CAP, 32'h5);
		apb(1'h1, `GTM_OFF_FLAGS, 32'h3);
		apb(1'h1, `GTM_OFF_COUNT, 32'h0);
		COMPARE_MODE <= 1'h1;
		AUTO_TRIG_EN <= 1'h1;
		tick(5, 1'h0);
		`CHK(seen_cmp, 1'h1)
		rd(`GTM_OFF_COUNT);
		`CHK(rdat[15:0], 16'h0)
		rd(`GTM_OFF_FLAGS);
		`CHK(rdat[`GTM_FLG_ROLL], 1'h0)
		COMPARE_MODE <= 1'h0;
		AUTO_TRIG_EN <= 1'h0;
		apb(1'h1, `GTM_OFF_COUNT, 32'h7);
		TRIG_OTHER <= 1'h1;
		@(posedge CLOCK);
		TRIG_OTHER <= 1'h0;
		rd(`GTM_OFF_COUNT);
		`CHK(rdat[15:0], 16'h0)
		tally_and_finish();
	end
endmodule // gtm_timer_bench
